// [design/hop_period_formula.sv]
`timescale 1ns/1ps
`default_nettype none
module hop_period_formula
(
  input  wire logic [tdma_budget_pkg::SLOT_W-1:0]   slots,
  input  wire logic [tdma_budget_pkg::BUDGET_W-1:0] base_budget,
  input  wire logic [tdma_budget_pkg::BUDGET_W-1:0] child_budget,
  output logic      [tdma_budget_pkg::PERIOD_W-1:0] raw_us,
  output logic      [tdma_budget_pkg::PERIOD_W-1:0] rounded_us
);
  import tdma_budget_pkg::*;

  logic [PERIOD_W-1:0] per_slot;
  logic [PERIOD_W-1:0] steps;

  // ==========================================================
  // Period before and after rounding
  always_comb
  begin
    per_slot   = PERIOD_W'(US_PER_BYTE * PERIOD_W'(child_budget)) + SLOT_OVH_US;
    raw_us     = PERIOD_W'(PERIOD_W'(slots) * per_slot)
               + PERIOD_W'(US_PER_BYTE * PERIOD_W'(base_budget)) + FRAME_OVH_US;
    steps      = (raw_us + PERIOD_STEP_M1) / PERIOD_STEP_US;
    rounded_us = PERIOD_W'(steps * PERIOD_STEP_US);
  end
endmodule
`default_nettype wire

// [design/slot_lease_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module slot_lease_timer
(
  input  wire logic                                clock,
  input  wire logic                                nrst,
  input  wire logic                                hop_tick,
  input  wire logic                                refresh,
  input  wire logic [tdma_budget_pkg::LEASE_W-1:0] reload,
  output logic                                     reserved
);
  import tdma_budget_pkg::*;

  logic [LEASE_W-1:0] hops_left_r;

  // ==========================================================
  // Lease countdown, refresh wins over tick
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      hops_left_r <= '0;
    else if (refresh)
      hops_left_r <= reload;
    else if (hop_tick && (hops_left_r != '0))
      hops_left_r <= hops_left_r - LEASE_W'(1);
  end

  assign reserved = (hops_left_r != '0);
endmodule
`default_nettype wire

// [design/tdma_budget_pkg.sv]
package tdma_budget_pkg;
  // ==========================================================
  // Widths
  localparam int BUDGET_W = 7;
  localparam int PERIOD_W = 17;
  localparam int SLOT_W   = 4;
  localparam int ID_W     = 3;
  localparam int MSG_W    = 4;
  localparam int LEASE_W  = 8;
  localparam int MAX_CHILDREN = 8;

  // ==========================================================
  // Byte budgets
  localparam logic [BUDGET_W-1:0] BASE_BUDGET_MAX  = 7'h69;
  localparam logic [BUDGET_W-1:0] BASE_SLOT_STEP   = 7'h03;
  localparam logic [BUDGET_W-1:0] HEADER_BYTES     = 7'h09;
  localparam logic [BUDGET_W-1:0] BASE_BUFFER_MAX  = 7'h72;
  localparam logic [BUDGET_W-1:0] CHILD_BUDGET_MAX = 7'h6d;
  localparam logic [BUDGET_W-1:0] CHILD_BUFFER_MAX = 7'h76;
  localparam logic [BUDGET_W-1:0] BUDGET_ZERO      = 7'h00;

  // ==========================================================
  // Hop period arithmetic, microseconds
  localparam logic [PERIOD_W-1:0] US_PER_BYTE    = 17'h00050;
  localparam logic [PERIOD_W-1:0] SLOT_OVH_US    = 17'h00988;
  localparam logic [PERIOD_W-1:0] FRAME_OVH_US   = 17'h00cd0;
  localparam logic [PERIOD_W-1:0] PERIOD_STEP_US = 17'h001f4;
  localparam logic [PERIOD_W-1:0] PERIOD_STEP_M1 = 17'h001f3;

  // ==========================================================
  // Reset values and slot count limits
  localparam logic [BUDGET_W-1:0] BASE_BUDGET_RST  = 7'h28;
  localparam logic [BUDGET_W-1:0] CHILD_BUDGET_RST = 7'h19;
  localparam logic [PERIOD_W-1:0] HOP_PERIOD_RST   = 17'h04e20;
  localparam logic [SLOT_W-1:0]   SLOT_COUNT_RST   = 4'h3;
  localparam logic [SLOT_W-1:0]   SLOT_COUNT_MIN   = 4'h1;
  localparam logic [SLOT_W-1:0]   SLOT_COUNT_MAX   = 4'h8;
  localparam logic [MSG_W-1:0]    MSG_LIMIT_RST    = 4'h8;
  localparam logic [LEASE_W-1:0]  LEASE_HOPS_RST   = 8'h04;

  // ==========================================================
  // Search state
  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b01,
    ST_SEARCH = 2'b10
  } calc_state_t;

  // ==========================================================
  // Largest base budget for a slot count
  function automatic logic [BUDGET_W-1:0] base_budget_cap(input logic [SLOT_W-1:0] slots);
    logic [BUDGET_W-1:0] extra;
    extra = BUDGET_W'(slots) - BUDGET_W'(SLOT_COUNT_MIN);
    base_budget_cap = BASE_BUDGET_MAX - BUDGET_W'(extra * BASE_SLOT_STEP);
  endfunction

  // Slot count forced into 1..8
  function automatic logic [SLOT_W-1:0] clamp_slots(input logic [SLOT_W-1:0] slots);
    if (slots < SLOT_COUNT_MIN)
      clamp_slots = SLOT_COUNT_MIN;
    else if (slots > SLOT_COUNT_MAX)
      clamp_slots = SLOT_COUNT_MAX;
    else
      clamp_slots = slots;
  endfunction
endpackage

// [design/tdma_slot_budget_calc.sv]
`timescale 1ns/1ps
`default_nettype none
module tdma_slot_budget_calc
(
  input  wire logic                                 clock,
  input  wire logic                                 nrst,
  input  wire logic                                 node_is_base,
  input  wire logic                                 cfg_write,
  input  wire logic [tdma_budget_pkg::BUDGET_W-1:0] base_budget_setting,
  input  wire logic [tdma_budget_pkg::SLOT_W-1:0]   slot_count_setting,
  input  wire logic [tdma_budget_pkg::PERIOD_W-1:0] hop_period_setting,
  input  wire logic [tdma_budget_pkg::MSG_W-1:0]    message_limit_setting,
  input  wire logic [tdma_budget_pkg::LEASE_W-1:0]  lease_hops_setting,
  input  wire logic                                 beacon_rx,
  input  wire logic [tdma_budget_pkg::SLOT_W-1:0]   beacon_slot_count,
  input  wire logic [tdma_budget_pkg::BUDGET_W-1:0] beacon_base_budget,
  input  wire logic [tdma_budget_pkg::PERIOD_W-1:0] beacon_hop_period,
  input  wire logic                                 hop_start,
  input  wire logic                                 hop_tx_begin,
  input  wire logic                                 msg_valid,
  input  wire logic [tdma_budget_pkg::BUDGET_W-1:0] msg_payload_len,
  input  wire logic                                 msg_fully_held,
  input  wire logic                                 child_request,
  input  wire logic [tdma_budget_pkg::ID_W-1:0]     child_request_id,
  output logic      [tdma_budget_pkg::BUDGET_W-1:0] base_payload_budget,
  output logic      [tdma_budget_pkg::BUDGET_W-1:0] child_payload_budget,
  output logic      [tdma_budget_pkg::SLOT_W-1:0]   child_slot_count,
  output logic      [tdma_budget_pkg::PERIOD_W-1:0] hop_period_us,
  output logic      [tdma_budget_pkg::MSG_W-1:0]    hop_message_limit,
  output logic      [tdma_budget_pkg::LEASE_W-1:0]  slot_reservation_hops,
  output logic      [tdma_budget_pkg::BUDGET_W-1:0] base_buffer_bytes,
  output logic      [tdma_budget_pkg::BUDGET_W-1:0] child_buffer_bytes,
  output logic                                      calc_busy,
  output logic                                      msg_accept,
  output logic                                      msg_reject,
  output logic      [tdma_budget_pkg::BUDGET_W-1:0] hop_bytes_used,
  output logic      [tdma_budget_pkg::MSG_W-1:0]    hop_msg_count,
  output logic                                      slot_grant,
  output logic                                      slot_deny,
  output logic      [tdma_budget_pkg::MAX_CHILDREN-1:0] slot_reserved
);
  import tdma_budget_pkg::*;

  // ==========================================================
  // Configuration registers
  logic [BUDGET_W-1:0] base_budget_r;
  logic [SLOT_W-1:0]   slot_count_r;
  logic [PERIOD_W-1:0] period_setting_r;
  logic [MSG_W-1:0]    msg_limit_r;
  logic [LEASE_W-1:0]  lease_hops_r;
  logic                recalc_r;
  logic [SLOT_W-1:0]   new_slots;
  logic [BUDGET_W-1:0] new_cap;
  logic                base_cfg;

  assign base_cfg  = cfg_write && node_is_base;
  assign new_slots = node_is_base ? clamp_slots(slot_count_setting)
                                  : clamp_slots(beacon_slot_count);
  assign new_cap   = base_budget_cap(new_slots);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      base_budget_r    <= BASE_BUDGET_RST;
      slot_count_r     <= SLOT_COUNT_RST;
      period_setting_r <= HOP_PERIOD_RST;
    end
    else if (base_cfg)
    begin
      slot_count_r     <= new_slots;
      base_budget_r    <= (base_budget_setting > new_cap) ? new_cap
                                                          : base_budget_setting;
      period_setting_r <= hop_period_setting;
    end
    else if (beacon_rx && !node_is_base)
    begin
      slot_count_r     <= new_slots;
      base_budget_r    <= (beacon_base_budget > new_cap) ? new_cap : beacon_base_budget;
      period_setting_r <= beacon_hop_period;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      msg_limit_r  <= MSG_LIMIT_RST;
      lease_hops_r <= LEASE_HOPS_RST;
    end
    else if (cfg_write)
    begin
      msg_limit_r  <= message_limit_setting;
      lease_hops_r <= lease_hops_setting;
    end
  end

  // ==========================================================
  // Child budget search
  calc_state_t         state_r;
  logic [BUDGET_W-1:0] cand_r;
  logic [BUDGET_W-1:0] child_budget_r;
  logic [PERIOD_W-1:0] period_r;
  logic [PERIOD_W-1:0] raw_us;
  logic [PERIOD_W-1:0] rounded_us;
  logic                cand_fits;
  logic                busy_r;

  hop_period_formula u_formula
  (
    .slots        (slot_count_r),
    .base_budget  (base_budget_r),
    .child_budget (cand_r),
    .raw_us       (raw_us),
    .rounded_us   (rounded_us)
  );

  assign cand_fits = (raw_us <= period_setting_r) || (cand_r == BUDGET_ZERO);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      recalc_r <= 1'b0;
    else if (base_cfg || (beacon_rx && !node_is_base))
      recalc_r <= 1'b1;
    else if (state_r == ST_IDLE)
      recalc_r <= 1'b0;
  end

  // Busy flag, same timing as search or pending recalc
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      busy_r <= 1'b0;
    else
      busy_r <= base_cfg || (beacon_rx && !node_is_base) || recalc_r
             || ((state_r == ST_SEARCH) && !cand_fits);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= ST_IDLE;
      cand_r  <= CHILD_BUDGET_MAX;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (recalc_r)
          begin
            state_r <= ST_SEARCH;
            cand_r  <= CHILD_BUDGET_MAX;
          end
        end
        ST_SEARCH:
        begin
          if (cand_fits)
            state_r <= ST_IDLE;
          else
            cand_r <= cand_r - BUDGET_W'(1);
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      child_budget_r <= CHILD_BUDGET_RST;
      period_r       <= HOP_PERIOD_RST;
    end
    else if ((state_r == ST_SEARCH) && cand_fits)
    begin
      child_budget_r <= cand_r;
      period_r       <= rounded_us;
    end
  end

  // ==========================================================
  // Buffer sizes
  logic [BUDGET_W-1:0] base_buf_r;
  logic [BUDGET_W-1:0] child_buf_r;
  logic [BUDGET_W-1:0] base_buf_nxt;
  logic [BUDGET_W-1:0] child_buf_nxt;

  always_comb
  begin
    base_buf_nxt  = base_budget_r + HEADER_BYTES;
    child_buf_nxt = child_budget_r + HEADER_BYTES;
    if (base_buf_nxt > BASE_BUFFER_MAX)
      base_buf_nxt = BASE_BUFFER_MAX;
    if (child_buf_nxt > CHILD_BUFFER_MAX)
      child_buf_nxt = CHILD_BUFFER_MAX;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      base_buf_r  <= BASE_BUDGET_RST + HEADER_BYTES;
      child_buf_r <= CHILD_BUDGET_RST + HEADER_BYTES;
    end
    else
    begin
      base_buf_r  <= base_buf_nxt;
      child_buf_r <= child_buf_nxt;
    end
  end

  // ==========================================================
  // Per-hop message packing
  logic [BUDGET_W-1:0] used_r;
  logic [MSG_W-1:0]    count_r;
  logic                tx_started_r;
  logic                accept_r;
  logic                reject_r;
  logic [BUDGET_W-1:0] hop_buf;
  logic [BUDGET_W:0]   need;
  logic                fits;

  assign hop_buf = node_is_base ? base_buf_r : child_buf_r;
  assign need    = {1'b0, used_r} + {1'b0, msg_payload_len} + {1'b0, HEADER_BYTES};
  assign fits    = msg_fully_held && !tx_started_r
                && (count_r < msg_limit_r)
                && (need <= {1'b0, hop_buf});

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      tx_started_r <= 1'b0;
    else if (hop_start)
      tx_started_r <= 1'b0;
    else if (hop_tx_begin)
      tx_started_r <= 1'b1;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      used_r  <= BUDGET_ZERO;
      count_r <= '0;
    end
    else if (hop_start)
    begin
      used_r  <= BUDGET_ZERO;
      count_r <= '0;
    end
    else if (msg_valid && fits)
    begin
      used_r  <= need[BUDGET_W-1:0];
      count_r <= count_r + MSG_W'(1);
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      accept_r <= 1'b0;
      reject_r <= 1'b0;
    end
    else
    begin
      accept_r <= msg_valid && !hop_start && fits;
      reject_r <= msg_valid && !(!hop_start && fits);
    end
  end

  // ==========================================================
  // Slot leases and child admission
  logic [MAX_CHILDREN-1:0] reserved;
  logic [MAX_CHILDREN-1:0] refresh;
  logic [SLOT_W-1:0]       reserved_count;
  logic                    admit;
  logic                    grant_r;
  logic                    deny_r;
  logic [MAX_CHILDREN-1:0] reserved_r;

  genvar gi;
  generate
    for (gi = 0; gi < MAX_CHILDREN; gi++)
    begin : g_lease
      assign refresh[gi] = child_request && admit && node_is_base
                        && (child_request_id == ID_W'(gi));
      slot_lease_timer u_lease
      (
        .clock    (clock),
        .nrst     (nrst),
        .hop_tick (hop_start),
        .refresh  (refresh[gi]),
        .reload   (lease_hops_r),
        .reserved (reserved[gi])
      );
    end
  endgenerate

  always_comb
  begin
    reserved_count = '0;
    for (int i = 0; i < MAX_CHILDREN; i++)
      reserved_count = reserved_count + SLOT_W'(reserved[i]);
  end

  assign admit = reserved[child_request_id]
              || (reserved_count < slot_count_r);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      grant_r    <= 1'b0;
      deny_r     <= 1'b0;
      reserved_r <= '0;
    end
    else
    begin
      grant_r    <= child_request && node_is_base && admit;
      deny_r     <= child_request && node_is_base && !admit;
      reserved_r <= reserved;
    end
  end

  // ==========================================================
  // Outputs
  assign base_payload_budget   = base_budget_r;
  assign child_payload_budget  = child_budget_r;
  assign child_slot_count      = slot_count_r;
  assign hop_period_us         = period_r;
  assign hop_message_limit     = msg_limit_r;
  assign slot_reservation_hops = lease_hops_r;
  assign base_buffer_bytes     = base_buf_r;
  assign child_buffer_bytes    = child_buf_r;
  assign calc_busy             = busy_r;
  assign msg_accept            = accept_r;
  assign msg_reject            = reject_r;
  assign hop_bytes_used        = used_r;
  assign hop_msg_count         = count_r;
  assign slot_grant            = grant_r;
  assign slot_deny             = deny_r;
  assign slot_reserved         = reserved_r;
endmodule
`default_nettype wire

// [sim/child_radio_model.sv]
`timescale 1ns/1ps
`default_nettype none
module child_radio_model
(
  input wire logic       clock,
  input wire logic       go,
  input wire logic [2:0] id_in,
  output var logic       child_request,
  output var logic [2:0] child_request_id
);
  // ==========================================================
  // Slot request, id scrambled while idle
  initial child_request = 1'b0;
  initial child_request_id = 3'h0;
  always @(posedge clock)
  begin
    child_request <= go;
    child_request_id <= go ? id_in : ~child_request_id;
  end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tdma_budget_pkg::*;
  // ==========================================================
  // Stimulus and design
  logic clock = 0, nrst = 0, base = 1, cfg = 0, bcn = 0, hs = 0, txb = 0;
  logic mv = 0, held = 0, go = 0, busy, acc, rej, grant, deny, creq;
  logic [6:0] b_set = 0, bb = 0, mlen = 0, bud, cbud, bbuf, cbuf, used;
  logic [3:0] s_set = 0, lim = 0, bs = 0, slots, mlim, mcnt;
  logic [16:0] p_set = 0, bp = 0, per;
  logic [7:0] lease = 0, lh, rsv;
  logic [2:0] gid = 0, cid;
  int fail_count = 0, checked = 0, seed = 60355;
  int mu, mc, ml, bufsz, ns, ll, rq, lc[8];
  bit txd;
  always #20 clock = ~clock;
  child_radio_model partner (.clock(clock), .go(go), .id_in(gid), .child_request(creq),
    .child_request_id(cid));
  tdma_slot_budget_calc uut (.clock(clock), .nrst(nrst), .node_is_base(base), .cfg_write(cfg),
    .base_budget_setting(b_set), .slot_count_setting(s_set), .hop_period_setting(p_set),
    .message_limit_setting(lim), .lease_hops_setting(lease), .beacon_rx(bcn),
    .beacon_slot_count(bs), .beacon_base_budget(bb), .beacon_hop_period(bp),
    .hop_start(hs), .hop_tx_begin(txb), .msg_valid(mv), .msg_payload_len(mlen),
    .msg_fully_held(held), .child_request(creq), .child_request_id(cid),
    .base_payload_budget(bud), .child_payload_budget(cbud), .child_slot_count(slots),
    .hop_period_us(per), .hop_message_limit(mlim), .slot_reservation_hops(lh),
    .base_buffer_bytes(bbuf), .child_buffer_bytes(cbuf), .calc_busy(busy),
    .msg_accept(acc), .msg_reject(rej), .hop_bytes_used(used), .hop_msg_count(mcnt),
    .slot_grant(grant), .slot_deny(deny), .slot_reserved(rsv));
  // ==========================================================
  // Helpers and reference model
  task step;
    @(posedge clock);
    #1;
  endtask
  task chk(input logic [16:0] s, input logic [16:0] e);
    checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task wait_idle;
    int n;
    n = 0;
    step;
    while (busy !== 1'b0 && n < 300)
    begin
      step;
      n++;
    end
    if (n == 300)
    begin
      fail_count++;
      finish_test;
    end
    step;
  endtask
  function automatic int raw(int s, int b, int r);
    return s*(80*r + 2440) + 80*b + 3280;
  endfunction
  task cfg_chk(int s, int b, int hp);
    rq = -1;
    for (int i = 109; i >= 0; i--)
      if (rq < 0 && raw(s, b, i) <= hp)
        rq = i;
    if (rq < 0)
      rq = 0;
    chk(slots, s);
    chk(bud, b);
    chk(cbud, rq);
    chk(per, (raw(s, b, rq) + 499)/500*500);
    chk(bbuf, b + 9);
    chk(cbuf, rq + 9);
  endtask
  task do_cfg(int s, int b, int hp, int l, int ls);
    s_set = s;
    b_set = b;
    p_set = hp;
    lim = l;
    lease = ls;
    cfg = 1;
    step;
    cfg = 0;
    wait_idle;
    ml = l;
    ll = ls;
    chk(mlim, l);
    chk(lh, ls);
    if (base)
    begin
      ns = s < 1 ? 1 : s > 8 ? 8 : s;
      b = b > 108 - 3*ns ? 108 - 3*ns : b;
      cfg_chk(ns, b, hp);
      bufsz = b + 9;
    end
  endtask
  task hop;
    hs = 1;
    step;
    hs = 0;
    mu = 0;
    mc = 0;
    txd = 0;
    foreach (lc[i])
      if (lc[i] > 0)
        lc[i]--;
    step;
  endtask
  task msg(int len, bit h);
    bit ex;
    mlen = len;
    held = h;
    mv = 1;
    step;
    mv = 0;
    ex = h && !txd && mc < ml && mu + len + 9 <= bufsz;
    if (ex)
    begin
      mu += len + 9;
      mc++;
    end
    chk(acc, ex);
    chk(rej, !ex);
    chk(used, mu);
    chk(mcnt, mc);
    step;
  endtask
  task req(int id);
    int n;
    bit g;
    n = 0;
    foreach (lc[i])
      n += lc[i] > 0;
    g = lc[id] > 0 || n < ns;
    gid = id;
    go = 1;
    step;
    go = 0;
    step;
    chk(grant, g);
    chk(deny, !g);
    if (g)
      lc[id] = ll;
    step;
    foreach (lc[i])
      chk(rsv[i], lc[i] > 0);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    foreach (lc[i])
      lc[i] = 0;
    repeat (3) step;
    nrst = 1;
    step;
    cfg_chk(3, 40, 20000);
    chk(mlim, 8);
    chk(lh, 4);
    chk(rsv, 0);
    do_cfg(1, 120, 40000, 8, 4);
    do_cfg(8, 90, 131071, 8, 4);
    do_cfg(0, 30, 15000, 8, 4);
    do_cfg(9, 20, 9000, 8, 4);
    do_cfg(4, 96, 55600, 8, 4);
    do_cfg(4, 96, 55599, 8, 4);
    repeat (6)
      do_cfg(1 + {$random(seed)} % 8, 20 + {$random(seed)} % 90,
             20000 + {$random(seed)} % 100000, 8, 4);
    // Budgets kept at 20 or more for whole messages
    do_cfg(2, 90, 60000, 3, 4);
    hop;
    msg(30, 1);
    msg(30, 1);
    msg(12, 1);
    msg(0, 1);
    hop;
    msg(73, 1);
    msg(9, 1);
    msg(8, 1);
    repeat (4)
    begin
      hop;
      repeat (5)
      begin
        if ($random(seed) % 4 == 0)
        begin
          txb = 1;
          step;
          txb = 0;
          txd = 1;
        end
        msg({$random(seed)} % 60, $random(seed) % 5 != 0);
      end
    end
    do_cfg(2, 90, 60000, 0, 4);
    hop;
    msg(1, 1);
    do_cfg(2, 90, 60000, 8, 2);
    req(0);
    req(1);
    req(2);
    req(0);
    hop;
    hop;
    req(2);
    base = 0;
    nrst = 0;
    step;
    nrst = 1;
    step;
    do_cfg(1, 100, 40000, 5, 4);
    cfg_chk(3, 40, 20000);
    bs = 2;
    bb = 50;
    bp = 30000;
    bcn = 1;
    step;
    bcn = 0;
    wait_idle;
    cfg_chk(2, 50, 30000);
    bufsz = rq + 9;
    hop;
    msg(rq, 1);
    msg(0, 1);
    finish_test;
  end
endmodule
`default_nettype wire

// [sim/tdma_budget_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module tdma_budget_checker
(
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       node_is_base,
  input wire logic       msg_valid,
  input wire logic       msg_fully_held,
  input wire logic       msg_accept,
  input wire logic       msg_reject,
  input wire logic       child_request,
  input wire logic       slot_grant,
  input wire logic       slot_deny,
  input wire logic       calc_busy,
  input wire logic [6:0] base_payload_budget,
  input wire logic [6:0] child_payload_budget,
  input wire logic [6:0] base_buffer_bytes,
  input wire logic [6:0] child_buffer_bytes,
  input wire logic [6:0] hop_bytes_used,
  input wire logic [3:0] child_slot_count,
  input wire logic [3:0] hop_msg_count,
  input wire logic [3:0] hop_message_limit
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Assertions
  held_only_a: assert property (msg_valid && !msg_fully_held |=> msg_reject)
    else $error("message not fully held was taken");
  one_answer_a: assert property (msg_valid |=> msg_accept != msg_reject)
    else $error("message offer without single answer");
  base_cap_a: assert property (!calc_busy |-> base_payload_budget + 3*child_slot_count <= 108)
    else $error("base budget above slot cap");
  base_buf_a: assert property (!calc_busy && !$past(calc_busy) |->
    base_buffer_bytes == base_payload_budget + 7'h09)
    else $error("base buffer not budget plus header");
  child_buf_a: assert property (!calc_busy && !$past(calc_busy) |->
    child_buffer_bytes == child_payload_budget + 7'h09)
    else $error("child buffer not budget plus header");
  child_max_a: assert property (child_payload_budget <= 7'h6d)
    else $error("child budget above maximum");
  fit_buf_a: assert property (msg_accept |->
    hop_bytes_used <= (node_is_base ? base_buffer_bytes : child_buffer_bytes))
    else $error("accepted message overflows buffer");
  msg_limit_a: assert property (msg_accept |->
    hop_msg_count != 4'h0 && hop_msg_count <= hop_message_limit)
    else $error("message count beyond hop limit");
  grant_answer_a: assert property (child_request && node_is_base |=> slot_grant ^ slot_deny)
    else $error("slot request without single answer");
  busy_bound_a: assert property ($rose(calc_busy) |-> ##[1:150] !calc_busy)
    else $error("budget search too long");
  cover property (msg_accept);
  cover property (slot_deny);
  cover property ($fell(calc_busy));
endmodule
bind tdma_slot_budget_calc tdma_budget_checker u_chk (.*);
`default_nettype wire
